//--- hdl/cpw_params.svh
/*
 Constants of the complementary PWM channel: register offsets, field
 positions, reset values and prescaler terminal counts.
 Assumes inclusion by bare name from the package and the channel module.
*/
`ifndef CPW_PARAMS_SVH
`define CPW_PARAMS_SVH
`define CPW_ADDR_PER_LO  4'h0
`define CPW_ADDR_PER_HI  4'h1
`define CPW_ADDR_DUTY_LO 4'h2
`define CPW_ADDR_DUTY_HI 4'h3
`define CPW_ADDR_DT_LO   4'h4
`define CPW_ADDR_DT_HI   4'h5
`define CPW_ADDR_ENABLE  4'h6
`define CPW_ADDR_CONTROL 4'h7
`define CPW_BIT_RUN      0
`define CPW_BIT_PRI_EN   1
`define CPW_BIT_SEC_EN   2
`define CPW_BIT_MODE     3
`define CPW_BIT_FLT_EN   4
`define CPW_BIT_FLT_LVL  5
`define CPW_BIT_POL      2
`define CPW_BIT_FLT_ACT  4
`define CPW_BIT_FLT_ST   5
`define CPW_BIT_OVF      6
`define CPW_BIT_IRQ_EN   7
`define CPW_RST_BYTE     8'h00
`define CPW_RST_WORD     12'h000
`define CPW_CNT_START    12'h001
`define CPW_DIV1_TERM    7'h00
`define CPW_DIV8_TERM    7'h07
`define CPW_DIV32_TERM   7'h1F
`define CPW_DIV128_TERM  7'h7F
`endif

//--- hdl/cpw_pkg.sv
/*
 Types of the complementary PWM channel: bus request and pin pair.
 Assumes the constants header sits beside this file.
*/
`include "cpw_params.svh"
package cpw_pkg;
  typedef logic [11:0] cpw_word_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } cpw_req_s;
  typedef struct packed {
    logic pri;
    logic sec;
  } cpw_pins_s;
endpackage

//--- hdl/cpw_channel.sv
/*
 One 12-bit PWM channel with primary and secondary outputs, dead time,
 fault forcing, prescaler and overflow flag, behind a plain register port.
 Assumes one clock, a synchronous active-high reset, and an asynchronous
 fault pin; the bus master never drives both strobes at once.
*/
`timescale 1ns/1ps
`include "cpw_params.svh"
module cpw_channel (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire cpw_pkg::cpw_req_s bus_req,
  output logic [7:0]            rdata,
  input  wire logic             fault_input,
  output cpw_pkg::cpw_pins_s    pins,
  output logic                  irq
);

  // Software-visible register images
  logic [7:0] per_lo_q, per_lo_d, duty_lo_q, duty_lo_d, dt_lo_q, dt_lo_d;
  logic [3:0] per_hi_q, per_hi_d, duty_hi_q, duty_hi_d, dt_hi_q, dt_hi_d;
  logic [6:0] en_q, en_d;
  logic [7:0] con_q, con_d;
  // Committed and active compare values
  cpw_pkg::cpw_word_t per_com_q, per_com_d, per_act_q, per_act_d;
  cpw_pkg::cpw_word_t duty_com_q, duty_com_d, duty_act_q, duty_act_d;
  cpw_pkg::cpw_word_t dt_com_q, dt_com_d, dt_act_q, dt_act_d;
  cpw_pkg::cpw_word_t cnt_q, cnt_d;
  logic [6:0] pre_q, pre_d, div_term;
  logic [7:0] rdata_q, rdata_d;
  logic       flt_s1_q, flt_s2_q;
  cpw_pkg::cpw_pins_s pins_q, pins_d;
  logic       run_q, tick, ovf, flt_hit, pri_act, sec_act;
  logic       wr_en, wr_con;

  assign run_q  = en_q[`CPW_BIT_RUN];
  assign wr_en  = bus_req.we && (bus_req.addr == `CPW_ADDR_ENABLE);
  assign wr_con = bus_req.we && (bus_req.addr == `CPW_ADDR_CONTROL);

  // Prescaler terminal count from the divider select
  always_comb begin
    unique case (con_q[1:0])
      2'h0: div_term = `CPW_DIV1_TERM;
      2'h1: div_term = `CPW_DIV8_TERM;
      2'h2: div_term = `CPW_DIV32_TERM;
      2'h3: div_term = `CPW_DIV128_TERM;
    endcase
  end

  assign tick = run_q && (pre_q == div_term);
  // Period zero overflows every work clock rather than hanging
  assign ovf  = tick && (cnt_q >= per_act_q);
  // Enabled fault pin at its selected level; read only after two flops
  assign flt_hit = en_q[`CPW_BIT_FLT_EN]
                   && (flt_s2_q == con_q[`CPW_BIT_FLT_ACT]);

  // Waveform compare; in complementary mode the dead band sits at both edges of the duty
  always_comb begin
    if (en_q[`CPW_BIT_MODE]) begin
      pri_act = (cnt_q <= duty_act_q);
      sec_act = (cnt_q <= dt_act_q);
    end else begin
      pri_act = (cnt_q > dt_act_q) && (cnt_q <= duty_act_q);
      sec_act = ({1'b0, cnt_q} > ({1'b0, duty_act_q} + {1'b0, dt_act_q}));
    end
  end

  // Next state of counter, registers, flags and outputs
  always_comb begin
    per_lo_d   = per_lo_q;
    per_hi_d   = per_hi_q;
    duty_lo_d  = duty_lo_q;
    duty_hi_d  = duty_hi_q;
    dt_lo_d    = dt_lo_q;
    dt_hi_d    = dt_hi_q;
    en_d       = en_q;
    con_d      = con_q;
    per_com_d  = per_com_q;
    duty_com_d = duty_com_q;
    dt_com_d   = dt_com_q;
    per_act_d  = per_act_q;
    duty_act_d = duty_act_q;
    dt_act_d   = dt_act_q;
    cnt_d      = cnt_q;
    pre_d      = run_q ? (tick ? 7'h00 : pre_q + 7'h01) : 7'h00;
    rdata_d    = 8'h00;
    // Counting; a stopped channel freezes its count
    if (tick) begin
      if (ovf) begin
        cnt_d      = `CPW_CNT_START;
        per_act_d  = per_com_q;
        duty_act_d = duty_com_q;
        dt_act_d   = dt_com_q;
      end else begin
        cnt_d = cnt_q + 12'h001;
      end
    end
    // Register writes; the lower byte commits the joined value
    if (bus_req.we) begin
      unique case (bus_req.addr)
        `CPW_ADDR_PER_LO: begin
          per_lo_d  = bus_req.wdata;
          per_com_d = {per_hi_q, bus_req.wdata};
        end
        `CPW_ADDR_PER_HI:  per_hi_d = bus_req.wdata[3:0];
        `CPW_ADDR_DUTY_LO: begin
          duty_lo_d  = bus_req.wdata;
          duty_com_d = {duty_hi_q, bus_req.wdata};
        end
        `CPW_ADDR_DUTY_HI: duty_hi_d = bus_req.wdata[3:0];
        `CPW_ADDR_DT_LO: begin
          dt_lo_d  = bus_req.wdata;
          dt_com_d = {dt_hi_q, bus_req.wdata};
        end
        `CPW_ADDR_DT_HI:   dt_hi_d = bus_req.wdata[3:0];
        `CPW_ADDR_ENABLE:  en_d = bus_req.wdata[6:0];
        default: ;
      endcase
    end
    // Restart from 1 with fresh compare values on a run edge
    if (wr_en && !run_q && bus_req.wdata[`CPW_BIT_RUN]) begin
      cnt_d      = `CPW_CNT_START;
      pre_d      = 7'h00;
      per_act_d  = per_com_d;
      duty_act_d = duty_com_d;
      dt_act_d   = dt_com_d;
    end
    // Control: flags clear on a written zero, hardware set wins
    if (wr_con) begin
      con_d[`CPW_BIT_IRQ_EN] = bus_req.wdata[`CPW_BIT_IRQ_EN];
      con_d[4:0]             = bus_req.wdata[4:0];
      if (!bus_req.wdata[`CPW_BIT_OVF]) begin
        con_d[`CPW_BIT_OVF] = 1'b0;
      end
      if (!bus_req.wdata[`CPW_BIT_FLT_ST]) begin
        con_d[`CPW_BIT_FLT_ST] = 1'b0;
      end
    end
    if (ovf) begin
      con_d[`CPW_BIT_OVF] = 1'b1;
    end
    if (flt_hit) begin
      con_d[`CPW_BIT_FLT_ST] = 1'b1;
    end
    // Read data; unmapped offsets answer zero
    if (bus_req.re) begin
      unique case (bus_req.addr)
        `CPW_ADDR_PER_LO:  rdata_d = per_lo_q;
        `CPW_ADDR_PER_HI:  rdata_d = {4'h0, per_hi_q};
        `CPW_ADDR_DUTY_LO: rdata_d = duty_lo_q;
        `CPW_ADDR_DUTY_HI: rdata_d = {4'h0, duty_hi_q};
        `CPW_ADDR_DT_LO:   rdata_d = dt_lo_q;
        `CPW_ADDR_DT_HI:   rdata_d = {4'h0, dt_hi_q};
        `CPW_ADDR_ENABLE:  rdata_d = {1'b0, en_q};
        `CPW_ADDR_CONTROL: rdata_d = con_q;
        default:           rdata_d = 8'h00;
      endcase
    end
    // Outputs: fault levels first, then gated waveform with polarity
    if (con_q[`CPW_BIT_FLT_ST]) begin
      pins_d.pri = en_q[`CPW_BIT_FLT_LVL+1];
      pins_d.sec = en_q[`CPW_BIT_FLT_LVL];
    end else begin
      pins_d.pri = (run_q && en_q[`CPW_BIT_PRI_EN] && pri_act)
                   ^ con_q[`CPW_BIT_POL+1];
      pins_d.sec = (run_q && en_q[`CPW_BIT_SEC_EN] && sec_act)
                   ^ con_q[`CPW_BIT_POL];
    end
  end

  // Register stage; the fault pin passes two plain flops first
  always_ff @(posedge clk) begin
    flt_s1_q <= fault_input;
    flt_s2_q <= flt_s1_q;
    if (rst) begin
      per_lo_q   <= `CPW_RST_BYTE;
      per_hi_q   <= 4'h0;
      duty_lo_q  <= `CPW_RST_BYTE;
      duty_hi_q  <= 4'h0;
      dt_lo_q    <= `CPW_RST_BYTE;
      dt_hi_q    <= 4'h0;
      en_q       <= 7'h00;
      con_q      <= `CPW_RST_BYTE;
      per_com_q  <= `CPW_RST_WORD;
      duty_com_q <= `CPW_RST_WORD;
      dt_com_q   <= `CPW_RST_WORD;
      per_act_q  <= `CPW_RST_WORD;
      duty_act_q <= `CPW_RST_WORD;
      dt_act_q   <= `CPW_RST_WORD;
      cnt_q      <= `CPW_RST_WORD;
      pre_q      <= 7'h00;
      rdata_q    <= 8'h00;
      pins_q     <= '0;
    end else begin
      per_lo_q   <= per_lo_d;
      per_hi_q   <= per_hi_d;
      duty_lo_q  <= duty_lo_d;
      duty_hi_q  <= duty_hi_d;
      dt_lo_q    <= dt_lo_d;
      dt_hi_q    <= dt_hi_d;
      en_q       <= en_d;
      con_q      <= con_d;
      per_com_q  <= per_com_d;
      duty_com_q <= duty_com_d;
      dt_com_q   <= dt_com_d;
      per_act_q  <= per_act_d;
      duty_act_q <= duty_act_d;
      dt_act_q   <= dt_act_d;
      cnt_q      <= cnt_d;
      pre_q      <= pre_d;
      rdata_q    <= rdata_d;
      pins_q     <= pins_d;
    end
  end

  assign rdata = rdata_q;
  assign pins  = pins_q;
  // Level request; the system interrupt controller does the rest
  assign irq   = con_q[`CPW_BIT_IRQ_EN] && con_q[`CPW_BIT_OVF];

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_run_start;
    !run_q ##1 run_q;
  endsequence

  sequence s_stop;
    !run_q && !con_q[`CPW_BIT_FLT_ST];
  endsequence

  reserved_zero_a: assert property (
    bus_req.re && (bus_req.addr == `CPW_ADDR_PER_HI) |=> rdata[7:4] == 4'h0)
    else $error("upper nibble register read nonzero reserved bits");

  period_hold_a: assert property (
    !ovf && !$rose(en_d[`CPW_BIT_RUN]) |=> $stable(per_act_q))
    else $error("active period changed inside a cycle");

  restart_one_a: assert property (
    s_run_start |-> cnt_q == `CPW_CNT_START)
    else $error("counter did not restart from one");

  stop_off_a: assert property (
    s_stop |=> pins.pri == $past(con_q[`CPW_BIT_POL+1])
               && pins.sec == $past(con_q[`CPW_BIT_POL]))
    else $error("outputs not off while channel stopped");

  ovf_flag_a: assert property (
    ovf |=> con_q[`CPW_BIT_OVF] && cnt_q == `CPW_CNT_START)
    else $error("overflow did not set flag and restart");

  fault_force_a: assert property (
    con_q[`CPW_BIT_FLT_ST] |=> pins.pri == $past(en_q[`CPW_BIT_FLT_LVL+1])
                           && pins.sec == $past(en_q[`CPW_BIT_FLT_LVL]))
    else $error("fault levels not forced on outputs");

  fault_latch_a: assert property (
    flt_hit |=> con_q[`CPW_BIT_FLT_ST] [*2])
    else $error("fault state not latched");

  // Watched at the pins, so a broken compare or gate shows up here
  no_overlap_a: assert property (
    !en_q[`CPW_BIT_MODE] && !con_q[`CPW_BIT_FLT_ST]
    && !con_q[`CPW_BIT_POL+1] && !con_q[`CPW_BIT_POL]
    |=> !(pins.pri && pins.sec))
    else $error("complementary outputs active together");

  indep_sec_a: assert property (
    en_q[`CPW_BIT_MODE] && run_q && en_q[`CPW_BIT_SEC_EN] && !con_q[`CPW_BIT_FLT_ST]
    && !con_q[`CPW_BIT_POL] && (cnt_q <= dt_act_q) |=> pins.sec)
    else $error("independent secondary ignores dead-time value");

  timer_run_a: assert property (
    run_q && tick && !ovf |=> cnt_q == $past(cnt_q) + 12'h001)
    else $error("counter did not advance on work clock");

  pri_gate_a: assert property (
    !en_q[`CPW_BIT_PRI_EN] && !con_q[`CPW_BIT_FLT_ST]
    |=> pins.pri == $past(con_q[`CPW_BIT_POL+1]))
    else $error("disabled primary output not held inactive");

  sec_gate_a: assert property (
    !en_q[`CPW_BIT_SEC_EN] && !con_q[`CPW_BIT_FLT_ST]
    |=> pins.sec == $past(con_q[`CPW_BIT_POL]))
    else $error("disabled secondary output not held inactive");

  duty_hold_a: assert property (
    !ovf && !$rose(en_d[`CPW_BIT_RUN]) |=> $stable(duty_act_q) && $stable(dt_act_q))
    else $error("active duty changed inside a cycle");

  lo_commit_a: assert property (
    bus_req.we && (bus_req.addr == `CPW_ADDR_PER_LO)
    |=> per_com_q == {$past(per_hi_q), $past(bus_req.wdata)})
    else $error("lower byte write did not commit period");

  hi_pending_a: assert property (
    bus_req.we && (bus_req.addr == `CPW_ADDR_PER_HI) |=> $stable(per_com_q))
    else $error("upper nibble write committed period early");

  // A control write in the same cycle may drop the enable, so it is excluded
  irq_raise_a: assert property (
    ovf && con_q[`CPW_BIT_IRQ_EN] && !wr_con |=> irq)
    else $error("enabled overflow raised no request");

endmodule

//--- test/cpw_gate_model.sv
/*
 Gate-driver pair and fault source facing the PWM channel.
 Assumes the bench sets the fault level and when shoot-through is watched.
*/
`timescale 1ns/1ps
module cpw_gate_model (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire cpw_pkg::cpw_pins_s pins,
  input  wire logic               fault_req,
  input  wire logic               watch,
  output logic                    fault_input,
  output logic [11:0]             overlap_cnt
);
  // Channel pins arrive here already set up as outputs
  // Fault source drives a plain level, idle low
  assign fault_input = fault_req;

  // Both gates on in one leg would short the bridge; count such cycles
  always @(posedge clk) begin
    if (rst) begin
      overlap_cnt <= 12'h000;
    end else if (watch && pins.pri && pins.sec) begin
      overlap_cnt <= overlap_cnt + 12'h001;
    end
  end
endmodule

//--- test/complementary_pwm_channel_test.sv
/*
 Self-checking bench for the PWM channel: register access, waveforms,
 timer use, stop, polarity and fault forcing.
 Assumes the gate model file and the design files are compiled first.
*/
`timescale 1ns/1ps
module complementary_pwm_channel_test;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  cpw_pkg::cpw_req_s  req = '0;
  logic               fault_req = 1'b0;
  logic               watch = 1'b0;
  logic [7:0]         rdata;
  logic               fault_input;
  cpw_pkg::cpw_pins_s pins;
  logic               irq;
  logic [11:0]        overlap_cnt;
  logic [7:0]         rd_v;
  logic [11:0]        np;
  logic [11:0]        ns;
  int                 num_errors = 0;
  int                 samples_checked = 0;
  int                 div_n = 1;

  // 250 MHz system clock
  always #2 clk = ~clk;

  cpw_channel dut_u (.clk(clk), .rst(rst), .bus_req(req), .rdata(rdata),
    .fault_input(fault_input), .pins(pins), .irq(irq));
  cpw_gate_model gate_u (.clk(clk), .rst(rst), .pins(pins), .fault_req(fault_req),
    .watch(watch), .fault_input(fault_input), .overlap_cnt(overlap_cnt));

  // Compare and count
  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.we <= 1'b1;
    @(posedge clk);
    req.we <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    req.addr <= a;
    req.re <= 1'b1;
    @(posedge clk);
    req.re <= 1'b0;
    #1 rd_v = rdata;
  endtask

  // Stop first, then upper nibble before lower byte so each pair commits
  task automatic cfg(input logic [11:0] p, input logic [11:0] d, input logic [11:0] t,
                     input logic [7:0] en);
    wr(4'h6, 8'h00);
    wr(4'h1, {4'h0, p[11:8]});
    wr(4'h0, p[7:0]);
    wr(4'h3, {4'h0, d[11:8]});
    wr(4'h2, d[7:0]);
    wr(4'h5, {4'h0, t[11:8]});
    wr(4'h4, t[7:0]);
    wr(4'h6, en);
  endtask

  // Active cycles of each output over n clocks
  task automatic count(input int n);
    np = 12'h000;
    ns = 12'h000;
    repeat (n) begin
      @(posedge clk);
      #1;
      np = np + 12'(pins.pri);
      ns = ns + 12'(pins.sec);
    end
  endtask

  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 9; a++) begin
      rd(4'(a));
      chk("reset read", 12'(rd_v), 12'h000);
    end
    wr(4'h1, 8'hFF);
    rd(4'h1);
    chk("upper nibble", 12'(rd_v), 12'h00F);
    wr(4'h9, 8'hFF);
    rd(4'h9);
    chk("unmapped", 12'(rd_v), 12'h000);
    $display("test registers done");
    // Long period reaching the upper nibble, dead time of one
    cfg(12'h104, 12'h082, 12'h001, 8'h07);
    repeat (6) @(posedge clk);
    watch <= 1'b1;
    count(520);
    watch <= 1'b0;
    chk("comp primary", np, 12'h102);
    chk("comp secondary", ns, 12'h102);
    $display("test complementary done");
    // Every divider stretches each count; divide-by-one is left running
    for (int dv = 3; dv >= 0; dv--) begin
      div_n = (dv == 0) ? 1 : (2 << (2 * dv));
      wr(4'h7, {6'h00, 2'(dv)});
      cfg(12'h004, 12'h001, 12'h003, 8'h0F);
      repeat (6) @(posedge clk);
      count(16 * div_n);
      chk("indep primary", np, 12'(4 * div_n));
      chk("indep secondary", ns, 12'(12 * div_n));
    end
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h08);
    repeat (12) @(posedge clk);
    count(32);
    chk("new period pri", np, 12'h004);
    chk("new period sec", ns, 12'h00C);
    $display("test independent done");
    // Timer use with both outputs off
    wr(4'h6, 8'h09);
    repeat (3) @(posedge clk);
    #1;
    chk("outputs off", 12'(pins), 12'h000);
    wr(4'h7, 8'h00);
    repeat (12) @(posedge clk);
    rd(4'h7);
    chk("overflow flag", 12'(rd_v), 12'h040);
    wr(4'h7, 8'hC0);
    repeat (3) @(posedge clk);
    #1;
    chk("irq", 12'(irq), 12'h001);
    wr(4'h6, 8'h00);
    wr(4'h7, 8'h00);
    repeat (12) @(posedge clk);
    rd(4'h7);
    chk("stopped flag", 12'(rd_v), 12'h000);
    chk("stopped pins", 12'(pins), 12'h000);
    // Idle level of each output follows its own polarity bit
    for (int pl = 1; pl < 4; pl++) begin
      wr(4'h7, {4'h0, 2'(pl), 2'h0});
      repeat (3) @(posedge clk);
      #1;
      chk("idle polarity", 12'(pins), 12'(pl));
    end
    $display("test timer done");
    // Fault pin ignored until detection is enabled
    wr(4'h7, 8'h10);
    wr(4'h6, 8'h60);
    fault_req <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk("fault ignored", 12'(pins), 12'h000);
    for (int lv = 0; lv < 4; lv++) begin
      wr(4'h6, {1'b0, 2'(lv), 5'h10});
      repeat (6) @(posedge clk);
      #1;
      chk("fault level", 12'(pins), 12'(lv));
    end
    rd(4'h7);
    chk("fault state", 12'(rd_v), 12'h030);
    chk("overlap", overlap_cnt, 12'h000);
    // Low active level; a hit in the first clear cycle wins, so clear twice
    wr(4'h7, 8'h00);
    wr(4'h7, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    chk("fault cleared", 12'(pins), 12'h000);
    @(posedge clk);
    fault_req <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk("fault low level", 12'(pins), 12'h003);
    $display("test fault done");
    summarize();
  end

  // Watchdog well beyond the expected run of about four thousand clocks
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end
endmodule
